// ==== logic/scl_synth_channel_lock_control.v ====
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "scl_regs.vh"

module scl_synth_channel_lock_control #(
  parameter CF_CAL_CYCLES = `SCL_T_CF_CAL_CYC,
  parameter DCU_CAL_CYCLES = `SCL_T_DCU_CAL_CYC
) (
  input wire mclk, // 200 MHz clock
  input wire resetn, // Synchronous reset, active low
  input wire [7:0] reg_addr, // Register address
  input wire [7:0] reg_wdata, // Write data
  input wire reg_wr, // Write strobe
  input wire reg_rd, // Read strobe
  output reg [7:0] reg_rdata, // Read data, cycle after strobe
  input wire synth_locked_pin, // Lock detector from analogue core
  input wire tx_done, // Transmission completed normally
  input wire rx_done, // Reception completed normally
  input wire frame_start, // Frame begins in active state
  output wire irq, // Level interrupt
  output reg [12:0] synth_freq_q, // Carrier in 0.5 MHz units
  output reg freq_valid_q, // Frequency setting is not reserved
  output reg cf_cal_busy_q, // Centre calibration running
  output reg dcu_cal_busy_q, // Delay calibration running
  output reg [3:0] radio_state_q // Current radio state
);

  // ------------------------------------------------------------
  // Lock input synchroniser
  // ------------------------------------------------------------
  reg [2:0] lock_sync_q;
  reg lock_q;
  // Change counts only when stages two and three agree
  always @(posedge mclk)
  begin
    if (!resetn)
    begin
      lock_sync_q <= 3'b000;
      lock_q <= 1'b0;
    end
    else
    begin
      lock_sync_q <= {lock_sync_q[1:0], synth_locked_pin};
      if (lock_sync_q[1] == lock_sync_q[2])
        lock_q <= lock_sync_q[2];
    end
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  reg [4:0] channel_q;
  reg [2:0] chan_upper_q;
  reg [7:0] alt_num_q;
  reg [3:0] alt_band_q;
  reg [6:0] cf_value_q;
  reg [6:0] dcu_value_q;
  reg [1:0] irq_status_q;
  reg [1:0] irq_enable_q;
  reg [15:0] cf_cnt_q;
  reg [15:0] dcu_cnt_q;
  reg wait_lock_q; // Lock event pending once synthesizer settles
  reg settle_q; // Settling after normal transmit: no event

  wire wr_chan = reg_wr && (reg_addr == `SCL_ADDR_CHANNEL);
  wire wr_num = reg_wr && (reg_addr == `SCL_ADDR_ALT_NUM);
  wire wr_band = reg_wr && (reg_addr == `SCL_ADDR_ALT_BAND);
  wire wr_cf = reg_wr && (reg_addr == `SCL_ADDR_CF_CAL);
  wire wr_dcu = reg_wr && (reg_addr == `SCL_ADDR_DCU_CAL);
  wire wr_en = reg_wr && (reg_addr == `SCL_ADDR_IRQ_ENABLE);
  wire wr_clr = reg_wr && (reg_addr == `SCL_ADDR_IRQ_CLEAR);
  wire wr_req = reg_wr && (reg_addr == `SCL_ADDR_STATE_REQ);
  wire cf_start = wr_cf && reg_wdata[`SCL_START_BIT];
  wire dcu_start = wr_dcu && reg_wdata[`SCL_START_BIT];
  wire freq_change = wr_chan || wr_num || wr_band;

  // Active and idle-side states decoded in several places
  function is_active;
    input [3:0] st;
    begin
      is_active = (st == `SCL_ST_SYN_ON) || (st == `SCL_ST_LISTEN) ||
                  (st == `SCL_ST_ARET) || (st == `SCL_ST_AACK);
    end
  endfunction

  function is_syn_or_listen;
    input [3:0] st;
    begin
      is_syn_or_listen = (st == `SCL_ST_SYN_ON) || (st == `SCL_ST_LISTEN);
    end
  endfunction

  // Software-held configuration
  always @(posedge mclk)
  begin
    if (!resetn)
    begin
      {chan_upper_q, channel_q} <= `SCL_RST_CHANNEL;
      alt_num_q <= `SCL_RST_ALT_NUM;
      alt_band_q <= 4'h0;
      cf_value_q <= 7'h57;
      dcu_value_q <= 7'h20;
      irq_enable_q <= 2'b00;
    end
    else
    begin
      if (wr_chan)
      begin
        channel_q <= reg_wdata[4:0];
        chan_upper_q <= reg_wdata[7:5];
      end
      if (wr_num)
        alt_num_q <= reg_wdata;
      // Upper nibble has no storage, so it stays read-only
      if (wr_band)
        alt_band_q <= reg_wdata[3:0];
      if (wr_cf)
        cf_value_q <= reg_wdata[6:0];
      if (wr_dcu)
        dcu_value_q <= reg_wdata[6:0];
      if (wr_en)
        irq_enable_q <= reg_wdata[1:0];
    end
  end

  // ------------------------------------------------------------
  // Frequency decode
  // ------------------------------------------------------------
  reg [12:0] freq_d;
  reg valid_d;
  always @*
  begin
    freq_d = synth_freq_q;
    valid_d = 1'b0;
    case (alt_band_q)
      `SCL_BAND_STD:
      begin
        // Five MHz is ten half-MHz units per code
        valid_d = (channel_q >= `SCL_CHAN_MIN) && (channel_q <= `SCL_CHAN_MAX);
        freq_d = `SCL_F_STD_BASE + 13'd10 * {8'h00, channel_q - `SCL_CHAN_MIN};
      end
      `SCL_BAND_LOW:
      begin
        valid_d = (alt_num_q >= `SCL_NUM_LOW_MIN);
        freq_d = `SCL_F_LOW_BASE + {5'h00, alt_num_q};
      end
      `SCL_BAND_HIGH:
      begin
        valid_d = (alt_num_q <= `SCL_NUM_HIGH_MAX);
        freq_d = `SCL_F_HIGH_BASE + {5'h00, alt_num_q};
      end
      default:
      begin
        valid_d = 1'b0; // Reserved band keeps last frequency
        freq_d = synth_freq_q;
      end
    endcase
  end

  always @(posedge mclk)
  begin
    if (!resetn)
    begin
      synth_freq_q <= `SCL_F_STD_BASE;
      freq_valid_q <= 1'b1;
    end
    else
    begin
      synth_freq_q <= freq_d;
      freq_valid_q <= valid_d;
    end
  end

  // ------------------------------------------------------------
  // Calibration timers
  // ------------------------------------------------------------
  wire cf_done = cf_cal_busy_q && (cf_cnt_q == 16'h0001);
  wire dcu_done = dcu_cal_busy_q && (dcu_cnt_q == 16'h0001);
  // Both calibrations may run at once
  always @(posedge mclk)
  begin
    if (!resetn)
    begin
      cf_cal_busy_q <= 1'b0;
      cf_cnt_q <= 16'h0000;
      dcu_cal_busy_q <= 1'b0;
      dcu_cnt_q <= 16'h0000;
    end
    else
    begin
      if (cf_start)
      begin
        cf_cal_busy_q <= 1'b1;
        cf_cnt_q <= CF_CAL_CYCLES[15:0];
      end
      else if (cf_done)
        cf_cal_busy_q <= 1'b0;
      else if (cf_cal_busy_q)
        cf_cnt_q <= cf_cnt_q - 16'h0001;
      if (dcu_start)
      begin
        dcu_cal_busy_q <= 1'b1;
        dcu_cnt_q <= DCU_CAL_CYCLES[15:0];
      end
      else if (dcu_done)
        dcu_cal_busy_q <= 1'b0;
      else if (dcu_cal_busy_q)
        dcu_cnt_q <= dcu_cnt_q - 16'h0001;
    end
  end

  // ------------------------------------------------------------
  // Radio state and lock events
  // ------------------------------------------------------------
  reg [3:0] state_d;
  reg lock_ev;
  reg unlock_ev;
  reg wait_d;
  reg settle_d;
  reg lock_sync_prev_q;
  wire lock_rise = lock_q && !lock_sync_prev_q;
  wire lock_fall = !lock_q && lock_sync_prev_q;

  always @*
  begin
    state_d = radio_state_q;
    lock_ev = 1'b0;
    unlock_ev = 1'b0;
    wait_d = wait_lock_q;
    settle_d = settle_q;
    // Software-requested transitions
    if (wr_req)
    begin
      state_d = reg_wdata[3:0];
      if ((radio_state_q == `SCL_ST_OFF) && is_active(reg_wdata[3:0]))
        wait_d = 1'b1;
    end
    // Expected unlocks from retuning or manual centre calibration
    if (is_syn_or_listen(radio_state_q) && (freq_change || cf_start))
    begin
      unlock_ev = 1'b1;
      wait_d = 1'b1;
    end
    else if (is_active(radio_state_q) && freq_change)
      wait_d = 1'b1;
    if (cf_done)
      wait_d = 1'b1;
    // Lock reached: report unless centre cal is running or still settling after a transmit
    if (wait_lock_q && lock_q && !cf_cal_busy_q && !settle_q)
    begin
      lock_ev = 1'b1;
      wait_d = 1'b0;
    end
    // Unexpected loss of lock, and the relock that follows it
    if (lock_fall && !wait_lock_q && !settle_q)
      unlock_ev = 1'b1;
    if (lock_rise && !wait_lock_q && !settle_q && irq_status_q[`SCL_IRQ_UNLOCK])
      lock_ev = 1'b1;
    case (radio_state_q)
      `SCL_ST_BUSY_TX, `SCL_ST_BUSY_ARET:
      begin
        if (lock_fall || lock_rise)
          state_d = `SCL_ST_SYN_ON;
        else if (tx_done)
        begin
          state_d = (radio_state_q == `SCL_ST_BUSY_TX) ? `SCL_ST_SYN_ON : `SCL_ST_ARET;
          settle_d = 1'b1;
        end
      end
      `SCL_ST_BUSY_RX, `SCL_ST_BUSY_AACK:
      begin
        if (!lock_q)
          wait_d = 1'b1;
        if ((wait_lock_q && lock_q) || rx_done)
          state_d = (radio_state_q == `SCL_ST_BUSY_RX) ? `SCL_ST_LISTEN : `SCL_ST_AACK;
      end
      `SCL_ST_SYN_ON, `SCL_ST_ARET:
      begin
        if (settle_q && lock_q)
          settle_d = 1'b0;
        if (frame_start && (radio_state_q == `SCL_ST_ARET))
          state_d = `SCL_ST_BUSY_ARET;
      end
      `SCL_ST_LISTEN, `SCL_ST_AACK:
      begin
        if (frame_start)
          state_d = (radio_state_q == `SCL_ST_LISTEN) ? `SCL_ST_BUSY_RX : `SCL_ST_BUSY_AACK;
      end
      default:
        settle_d = 1'b0;
    endcase
  end

  always @(posedge mclk)
  begin
    if (!resetn)
    begin
      radio_state_q <= `SCL_ST_OFF;
      wait_lock_q <= 1'b0;
      settle_q <= 1'b0;
      lock_sync_prev_q <= 1'b0;
    end
    else
    begin
      radio_state_q <= state_d;
      wait_lock_q <= wait_d;
      settle_q <= settle_d;
      lock_sync_prev_q <= lock_q;
    end
  end

  // ------------------------------------------------------------
  // Interrupt status
  // ------------------------------------------------------------
  // Each new event wipes the opposite flag; set wins over clear
  always @(posedge mclk)
  begin
    if (!resetn)
      irq_status_q <= 2'b00;
    else
    begin
      if (lock_ev)
        irq_status_q <= 2'b01;
      else if (unlock_ev)
        irq_status_q <= 2'b10;
      else if (wr_clr)
        irq_status_q <= irq_status_q & ~reg_wdata[1:0];
    end
  end

  assign irq = |(irq_status_q & irq_enable_q);

  // ------------------------------------------------------------
  // Read port
  // ------------------------------------------------------------
  always @(posedge mclk)
  begin
    if (!resetn)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      case (reg_addr)
        `SCL_ADDR_CHANNEL: reg_rdata <= {chan_upper_q, channel_q};
        `SCL_ADDR_ALT_NUM: reg_rdata <= alt_num_q;
        `SCL_ADDR_ALT_BAND: reg_rdata <= {4'h0, alt_band_q};
        `SCL_ADDR_CF_CAL: reg_rdata <= {cf_cal_busy_q, cf_value_q};
        `SCL_ADDR_DCU_CAL: reg_rdata <= {dcu_cal_busy_q, dcu_value_q};
        `SCL_ADDR_IRQ_STATUS: reg_rdata <= {6'h00, irq_status_q};
        `SCL_ADDR_IRQ_ENABLE: reg_rdata <= {6'h00, irq_enable_q};
        `SCL_ADDR_RADIO_STATE: reg_rdata <= {4'h0, radio_state_q};
        default: reg_rdata <= 8'h00;
      endcase
    end
    else
      reg_rdata <= 8'h00;
  end

endmodule // scl_synth_channel_lock_control
`default_nettype wire

// ==== common/scl_regs.vh ====
`ifndef SCL_REGS_VH
`define SCL_REGS_VH
// Register offsets
`define SCL_ADDR_CHANNEL 8'h08
`define SCL_ADDR_ALT_NUM 8'h13
`define SCL_ADDR_ALT_BAND 8'h14
`define SCL_ADDR_CF_CAL 8'h1a
`define SCL_ADDR_DCU_CAL 8'h1b
`define SCL_ADDR_IRQ_STATUS 8'h0f
`define SCL_ADDR_IRQ_ENABLE 8'h30
`define SCL_ADDR_IRQ_CLEAR 8'h31
`define SCL_ADDR_RADIO_STATE 8'h32
`define SCL_ADDR_STATE_REQ 8'h33
// Reset values
`define SCL_RST_CHANNEL 8'h0b
`define SCL_RST_ALT_NUM 8'h00
`define SCL_RST_ALT_BAND 8'h00
`define SCL_RST_CF_CAL 8'h57
`define SCL_RST_DCU_CAL 8'h20
// Field values
`define SCL_CHAN_MIN 5'h0b
`define SCL_CHAN_MAX 5'h1a
`define SCL_BAND_STD 4'h0
`define SCL_BAND_LOW 4'h8
`define SCL_BAND_HIGH 4'h9
`define SCL_NUM_LOW_MIN 8'h20
`define SCL_NUM_HIGH_MAX 8'hba
`define SCL_START_BIT 7
`define SCL_IRQ_LOCK 0
`define SCL_IRQ_UNLOCK 1
// Frequency in half-MHz units
`define SCL_F_STD_BASE 13'h12ca
`define SCL_F_LOW_BASE 13'h1204
`define SCL_F_HIGH_BASE 13'h1304
// Timing: printed time in ns, clock period in ns
`define SCL_CLK_PERIOD_NS 5
`define SCL_T_CF_CAL_NS 8000
`define SCL_T_DCU_CAL_NS 6000
`define SCL_T_CF_CAL_CYC (`SCL_T_CF_CAL_NS / `SCL_CLK_PERIOD_NS)
`define SCL_T_DCU_CAL_CYC (`SCL_T_DCU_CAL_NS / `SCL_CLK_PERIOD_NS)
// Radio states
`define SCL_ST_OFF 4'h0
`define SCL_ST_SYN_ON 4'h1
`define SCL_ST_LISTEN 4'h2
`define SCL_ST_ARET 4'h3
`define SCL_ST_AACK 4'h4
`define SCL_ST_BUSY_TX 4'h5
`define SCL_ST_BUSY_ARET 4'h6
`define SCL_ST_BUSY_RX 4'h7
`define SCL_ST_BUSY_AACK 4'h8
`endif

// ==== test/scl_lock_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "scl_regs.vh"
// ----------------------------------------
// Checker on the top-level ports
// ----------------------------------------
module scl_lock_properties #(
  parameter CF_CAL_CYCLES = 8,
  parameter DCU_CAL_CYCLES = 8
) (
  input wire mclk, // Clock
  input wire resetn, // Sync reset, active low
  input wire [7:0] reg_addr, // Address
  input wire [7:0] reg_wdata, // Write data
  input wire reg_wr, // Write strobe
  input wire reg_rd, // Read strobe
  input wire [7:0] reg_rdata, // Read data
  input wire synth_locked_pin, // Lock level
  input wire tx_done, // Tx finished
  input wire rx_done, // Rx finished
  input wire frame_start, // Frame begins
  input wire irq, // Interrupt
  input wire [12:0] synth_freq_q, // Carrier
  input wire freq_valid_q, // Setting valid
  input wire cf_cal_busy_q, // Centre cal running
  input wire dcu_cal_busy_q, // Delay cal running
  input wire [3:0] radio_state_q // State
);
  logic [15:0] cf_cnt_q;
  logic [15:0] dcu_cnt_q;
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  // Busy run lengths; a counter avoids unrolling long repetitions
  always @(posedge mclk)
  begin
    cf_cnt_q <= (!resetn || !cf_cal_busy_q) ? 16'h0000 : cf_cnt_q + 16'h0001;
    dcu_cnt_q <= (!resetn || !dcu_cal_busy_q) ? 16'h0000 : dcu_cnt_q + 16'h0001;
  end
  sequence s_unlock_in_tx;
    radio_state_q == `SCL_ST_BUSY_TX && $fell(synth_locked_pin);
  endsequence
  sequence s_unlock_in_aret;
    radio_state_q == `SCL_ST_BUSY_ARET && $fell(synth_locked_pin);
  endsequence
  sequence s_back_on;
    ##[1:10] radio_state_q == `SCL_ST_SYN_ON;
  endsequence
  property p_band_ro;
    reg_rd && reg_addr == `SCL_ADDR_ALT_BAND |=> reg_rdata[7:4] == 4'h0;
  endproperty
  a_band_ro: assert property (p_band_ro) else $error("band upper nibble not zero");
  property p_one_flag;
    reg_rd && reg_addr == `SCL_ADDR_IRQ_STATUS |=> reg_rdata[1:0] != 2'b11;
  endproperty
  a_one_flag: assert property (p_one_flag) else $error("lock and unlock both flagged");
  property p_cf_start;
    reg_wr && reg_addr == `SCL_ADDR_CF_CAL && reg_wdata[7] |=> cf_cal_busy_q;
  endproperty
  a_cf_start: assert property (p_cf_start) else $error("centre cal did not start");
  property p_cf_len;
    $fell(cf_cal_busy_q) |-> $past(cf_cnt_q) >= CF_CAL_CYCLES - 1 && $past(cf_cnt_q) <= CF_CAL_CYCLES + 1;
  endproperty
  a_cf_len: assert property (p_cf_len) else $error("centre cal length wrong");
  property p_dcu_len;
    $fell(dcu_cal_busy_q) |-> $past(dcu_cnt_q) >= DCU_CAL_CYCLES - 1 && $past(dcu_cnt_q) <= DCU_CAL_CYCLES + 1;
  endproperty
  a_dcu_len: assert property (p_dcu_len) else $error("delay cal length wrong");
  property p_dcu_rd;
    reg_rd && reg_addr == `SCL_ADDR_DCU_CAL |=> reg_rdata[7] == $past(dcu_cal_busy_q);
  endproperty
  a_dcu_rd: assert property (p_dcu_rd) else $error("delay start bit wrong");
  property p_irq_mask;
    reg_wr && reg_addr == `SCL_ADDR_IRQ_ENABLE && reg_wdata == 8'h00 |=> !irq;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("masked interrupt raised");
  property p_tx_abort;
    s_unlock_in_tx |-> s_back_on;
  endproperty
  a_tx_abort: assert property (p_tx_abort) else $error("tx not aborted");
  property p_aret_abort;
    s_unlock_in_aret |-> s_back_on;
  endproperty
  a_aret_abort: assert property (p_aret_abort) else $error("retry tx not aborted");
  property p_dcu_start;
    reg_wr && reg_addr == `SCL_ADDR_DCU_CAL && reg_wdata[7] |=> dcu_cal_busy_q;
  endproperty
  a_dcu_start: assert property (p_dcu_start) else $error("delay cal did not start");
endmodule // scl_lock_properties
bind scl_synth_channel_lock_control scl_lock_properties #(.CF_CAL_CYCLES(CF_CAL_CYCLES),
  .DCU_CAL_CYCLES(DCU_CAL_CYCLES)) u_chk (.mclk(mclk), .resetn(resetn), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .synth_locked_pin(synth_locked_pin), .tx_done(tx_done), .rx_done(rx_done), .frame_start(frame_start),
  .irq(irq), .synth_freq_q(synth_freq_q), .freq_valid_q(freq_valid_q), .cf_cal_busy_q(cf_cal_busy_q),
  .dcu_cal_busy_q(dcu_cal_busy_q), .radio_state_q(radio_state_q));
`default_nettype wire

// ==== test/test_synth_channel_lock_control.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "scl_regs.vh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin bad_count++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
// ----------------------------------------
// Bench for the lock and channel block
// ----------------------------------------
module test_synth_channel_lock_control;
  typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] r; logic [12:0] f; logic v;} scl_row_t;
  localparam int CAL = 8; // Short calibration keeps the run brief
  logic mclk, resetn, reg_wr, reg_rd, synth_locked_pin, tx_done, rx_done, frame_start;
  logic [7:0] reg_addr, reg_wdata, rv;
  wire [7:0] reg_rdata;
  wire irq, freq_valid_q, cf_cal_busy_q, dcu_cal_busy_q;
  wire [12:0] synth_freq_q;
  wire [3:0] radio_state_q;
  int bad_count, total_checks, cyc, i;
  scl_row_t rows [11] = '{'{8'h08, 8'h0c, 8'h0c, 13'h12d4, 1'b1}, '{8'h08, 8'h1a, 8'h1a, 13'h1360, 1'b1},
    '{8'h13, 8'h20, 8'h20, 13'h1360, 1'b1}, '{8'h14, 8'hf8, 8'h08, 13'h1224, 1'b1},
    '{8'h13, 8'h1f, 8'h1f, 13'h0000, 1'b0}, '{8'h14, 8'h09, 8'h09, 13'h1323, 1'b1},
    '{8'h13, 8'hba, 8'hba, 13'h13be, 1'b1}, '{8'h13, 8'hbb, 8'hbb, 13'h0000, 1'b0},
    '{8'h14, 8'h05, 8'h05, 13'h0000, 1'b0}, '{8'h14, 8'h00, 8'h00, 13'h1360, 1'b1},
    '{8'h08, 8'h0a, 8'h0a, 13'h0000, 1'b0}};
  logic [7:0] rst_a [5] = '{`SCL_ADDR_CHANNEL, `SCL_ADDR_ALT_NUM, `SCL_ADDR_ALT_BAND, `SCL_ADDR_CF_CAL, `SCL_ADDR_DCU_CAL};
  logic [7:0] rst_v [5] = '{`SCL_RST_CHANNEL, `SCL_RST_ALT_NUM, `SCL_RST_ALT_BAND, `SCL_RST_CF_CAL, `SCL_RST_DCU_CAL};
  scl_synth_channel_lock_control #(.CF_CAL_CYCLES(CAL), .DCU_CAL_CYCLES(CAL)) i_dut (.mclk(mclk),
    .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .synth_locked_pin(synth_locked_pin), .tx_done(tx_done), .rx_done(rx_done),
    .frame_start(frame_start), .irq(irq), .synth_freq_q(synth_freq_q), .freq_valid_q(freq_valid_q),
    .cf_cal_busy_q(cf_cal_busy_q), .dcu_cal_busy_q(dcu_cal_busy_q), .radio_state_q(radio_state_q));
  // ----------------------------------------
  // Clock, bus tasks, closing
  // ----------------------------------------
  always #2.5 mclk = ~mclk;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge mclk) reg_wr <= 1'b0;
    #1;
  endtask
  // Read data is taken one cycle after the strobe, its only valid cycle
  task automatic rd(input logic [7:0] a);
    @(posedge mclk) {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge mclk) reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask
  // Polls status until the flags match, bounded so a miss cannot hang
  task automatic pst(input logic [1:0] e);
    for (int k = 0; k < 40; k++)
    begin
      rd(`SCL_ADDR_IRQ_STATUS);
      if (rv[1:0] === e) break;
    end
  endtask
  // One-cycle pulse: 0 frame start, 1 transmit done, 2 receive done
  task automatic pls(input int n);
    @(posedge mclk) {frame_start, tx_done, rx_done} <= 3'b100 >> n;
    @(posedge mclk) {frame_start, tx_done, rx_done} <= 3'b000;
    #1;
  endtask
  // Lock drops for ten cycles, then settles well past the synchroniser
  task automatic glitch;
    @(posedge mclk) synth_locked_pin <= 1'b0;
    repeat (10) @(posedge mclk);
    synth_locked_pin <= 1'b1;
    repeat (10) @(posedge mclk);
    #1;
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Hang guard, well above the expected length of the run
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      results;
    end
  end
  initial
  begin
    {mclk, resetn, reg_wr, reg_rd, tx_done, rx_done, frame_start, reg_addr, reg_wdata} = '0;
    synth_locked_pin = 1'b1;
    repeat (16) @(posedge mclk);
    resetn <= 1'b1;
    for (i = 0; i < 11; i++)
    begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a);
      `CHK(rv, rows[i].r)
      `CHK(freq_valid_q, rows[i].v)
      if (rows[i].v) `CHK(synth_freq_q, rows[i].f)
    end
    $display("table done");
    // Mid-run reset must bring the channel, band and calibration settings back
    @(posedge mclk) resetn <= 1'b0;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    for (i = 0; i < 5; i++)
    begin
      rd(rst_a[i]);
      `CHK(rv, rst_v[i])
    end
    `CHK(synth_freq_q, `SCL_F_STD_BASE)
    rd(8'h77);
    `CHK(rv, 8'h00)
    $display("reset done");
    // Leaving radio-off raises lock, then centre cal by read-modify-write
    wr(`SCL_ADDR_IRQ_ENABLE, 8'h03);
    wr(`SCL_ADDR_STATE_REQ, {4'h0, `SCL_ST_SYN_ON});
    pst(2'b01);
    `CHK(rv[1:0], 2'b01)
    `CHK(irq, 1'b1)
    wr(`SCL_ADDR_IRQ_CLEAR, 8'h01);
    `CHK(irq, 1'b0)
    rd(`SCL_ADDR_CF_CAL);
    wr(`SCL_ADDR_CF_CAL, rv | 8'h80);
    `CHK(cf_cal_busy_q, 1'b1)
    rd(`SCL_ADDR_CF_CAL);
    `CHK(rv[7], 1'b1)
    rd(`SCL_ADDR_IRQ_STATUS);
    `CHK(rv[1:0], 2'b10)
    pst(2'b01);
    `CHK(rv[1:0], 2'b01)
    `CHK(cf_cal_busy_q, 1'b0)
    wr(`SCL_ADDR_IRQ_ENABLE, 8'h00);
    `CHK(irq, 1'b0)
    // Retune in synthesizer-on: unlock flagged, then relock replaces it
    wr(`SCL_ADDR_IRQ_ENABLE, 8'h02);
    wr(`SCL_ADDR_CHANNEL, 8'h0c);
    `CHK(irq, 1'b1)
    pst(2'b01);
    `CHK(rv[1:0], 2'b01)
    wr(`SCL_ADDR_IRQ_ENABLE, 8'h03);
    $display("lock events done");
    // Delay cal start bit clears on its own
    wr(`SCL_ADDR_DCU_CAL, 8'ha0);
    `CHK(dcu_cal_busy_q, 1'b1)
    rd(`SCL_ADDR_DCU_CAL);
    `CHK(rv[7], 1'b1)
    repeat (CAL + 4) @(posedge mclk);
    rd(`SCL_ADDR_DCU_CAL);
    `CHK(rv, 8'h20)
    `CHK(dcu_cal_busy_q, 1'b0)
    // Losing lock in busy transmit aborts to synthesizer-on
    wr(`SCL_ADDR_STATE_REQ, {4'h0, `SCL_ST_BUSY_TX});
    @(posedge mclk) synth_locked_pin <= 1'b0;
    for (i = 0; i < 30 && radio_state_q !== `SCL_ST_SYN_ON; i++) @(posedge mclk);
    `CHK(radio_state_q, `SCL_ST_SYN_ON)
    pst(2'b10);
    `CHK(rv[1:0], 2'b10)
    // Unexpected unlock: host reads the state back before going on
    rd(`SCL_ADDR_RADIO_STATE);
    `CHK(rv, {4'h0, `SCL_ST_SYN_ON})
    @(posedge mclk) synth_locked_pin <= 1'b1;
    pst(2'b01);
    // Busy receive returns to listen once relocked
    wr(`SCL_ADDR_STATE_REQ, {4'h0, `SCL_ST_BUSY_RX});
    glitch;
    `CHK(radio_state_q, `SCL_ST_LISTEN)
    // Frame start and normal end of reception
    pls(0);
    `CHK(radio_state_q, `SCL_ST_BUSY_RX)
    pls(2);
    `CHK(radio_state_q, `SCL_ST_LISTEN)
    // Busy auto-ack receive returns to auto-ack once relocked
    wr(`SCL_ADDR_STATE_REQ, {4'h0, `SCL_ST_AACK});
    pls(0);
    `CHK(radio_state_q, `SCL_ST_BUSY_AACK)
    glitch;
    `CHK(radio_state_q, `SCL_ST_AACK)
    // Normal end of transmit raises no lock event
    wr(`SCL_ADDR_STATE_REQ, {4'h0, `SCL_ST_BUSY_TX});
    repeat (8) @(posedge mclk);
    wr(`SCL_ADDR_IRQ_CLEAR, 8'h03);
    pls(1);
    repeat (20) @(posedge mclk);
    rd(`SCL_ADDR_IRQ_STATUS);
    `CHK(rv[1:0], 2'b00)
    `CHK(radio_state_q, `SCL_ST_SYN_ON)
    // Auto-retry transmit: normal end back to retry state, no event
    wr(`SCL_ADDR_STATE_REQ, {4'h0, `SCL_ST_ARET});
    pls(0);
    `CHK(radio_state_q, `SCL_ST_BUSY_ARET)
    pls(1);
    `CHK(radio_state_q, `SCL_ST_ARET)
    repeat (20) @(posedge mclk);
    rd(`SCL_ADDR_IRQ_STATUS);
    `CHK(rv[1:0], 2'b00)
    // Lock loss in busy retry transmit aborts to synthesizer-on
    pls(0);
    glitch;
    `CHK(radio_state_q, `SCL_ST_SYN_ON)
    $display("state tests done");
    results;
  end
endmodule // test_synth_channel_lock_control
`default_nettype wire
